/* msc_cfg_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module msc_cfg_bank
  import msc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        nv_load_in,
  input  wire logic [7:0]  nv_addr_in,
  input  wire logic [7:0]  nv_data_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_hit_out,
  output logic             advance_mode_sel_out,
  output logic      [10:0] advance_time_value_out,
  output logic      [17:0] advance_time_cycles_out,
  output logic      [9:0]  stationary_threshold_out,
  output logic      [6:0]  sense_advance_angle_out,
  output logic             speed_detect_enable_out,
  output logic             reverse_drive_enable_out,
  output logic      [8:0]  reverse_drive_threshold_out,
  output logic      [10:0] open_loop_current_level_out,
  output logic      [12:0] open_loop_ramp_rate_out,
  output logic             brake_enable_out,
  output logic      [12:0] brake_done_time_out,
  output logic      [2:0]  control_coefficient_out,
  output logic      [12:0] startup_accel_second_out,
  output logic      [9:0]  startup_accel_first_out,
  output logic      [11:0] loop_handover_threshold_out,
  output logic             loop_handover_valid_out,
  output logic      [12:0] rotor_align_time_out,
  output logic      [3:0]  fault_detector_enables_out,
  output logic             mechanical_clamp_enable_out,
  output logic             mechanical_clamp_target_out,
  output logic             sense_release_mode_out
);
  logic [7:0]          cfg [MSC_NREG];
  logic [MSC_NREG-1:0] wr_sel;
  logic [MSC_NREG-1:0] ld_sel;
  logic                rd_hit;
  msc_code3_t          rd_idx;
  msc_nib_t            adv_sig;
  msc_code3_t          adv_shift;
  msc_adv_val_t        adv_val_next;
  msc_code5_t          ho_code;
  msc_ho_t             ho_next;

  // ----------------------------------------
  // Byte storage
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < MSC_NREG; gi++) begin : g_byte
      assign wr_sel[gi] = reg_wr_in && (reg_addr_in == MSC_ADV_TIMING_OFS + 8'(gi));
      assign ld_sel[gi] = nv_load_in && (nv_addr_in == MSC_ADV_TIMING_OFS + 8'(gi));
      msc_cfg_byte u_byte (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .wr_in      (wr_sel[gi]),
        .wdata_in   (reg_wdata_in),
        .ld_in      (ld_sel[gi]),
        .ld_data_in (nv_data_in),
        .q_out      (cfg[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  assign rd_hit = (reg_addr_in >= MSC_ADV_TIMING_OFS) && (reg_addr_in <= MSC_FAULT_OFS);
  assign rd_idx = msc_code3_t'(reg_addr_in - MSC_ADV_TIMING_OFS);

  // Unmapped reads answer zero rather than stale data
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= MSC_UNMAPPED_RD;
      reg_hit_out   <= 1'b0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_hit ? cfg[rd_idx] : MSC_UNMAPPED_RD;
      reg_hit_out   <= rd_hit;
    end
  end

  // ----------------------------------------
  // Commutation advance
  // ----------------------------------------
  assign adv_sig      = msc_nib_t'(cfg[MSC_IDX_ADV]);
  assign adv_shift    = msc_code3_t'(cfg[MSC_IDX_ADV] >> ADV_SHIFT_LSB);
  assign adv_val_next = msc_adv_val_t'(adv_sig) << adv_shift;

  // Product fits 18 bits: largest value 1920 units of 125 cycles
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      advance_mode_sel_out    <= 1'b0;
      advance_time_value_out  <= '0;
      advance_time_cycles_out <= '0;
    end else begin
      advance_mode_sel_out    <= cfg[MSC_IDX_ADV][ADV_MODE_BIT];
      advance_time_value_out  <= adv_val_next;
      advance_time_cycles_out <= msc_adv_cyc_t'(adv_val_next * ADV_UNIT_CYC);
    end
  end

  // ----------------------------------------
  // Speed detection and reverse drive
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      stationary_threshold_out    <= '0;
      sense_advance_angle_out     <= '0;
      speed_detect_enable_out     <= 1'b0;
      reverse_drive_enable_out    <= 1'b0;
      reverse_drive_threshold_out <= '0;
    end else begin
      stationary_threshold_out    <= STAT_MS[msc_code2_t'(cfg[MSC_IDX_SPD] >> STAT_LSB)];
      sense_advance_angle_out     <= ANGLE_DEG[msc_code2_t'(cfg[MSC_IDX_SPD] >> ANGLE_LSB)];
      speed_detect_enable_out     <= cfg[MSC_IDX_SPD][ISD_EN_BIT];
      reverse_drive_enable_out    <= cfg[MSC_IDX_SPD][REV_EN_BIT];
      reverse_drive_threshold_out <= REV_THR_DHZ[msc_code2_t'(cfg[MSC_IDX_SPD])];
    end
  end

  // ----------------------------------------
  // Open-loop current and braking
  // ----------------------------------------
  // The two slowest ramp codes are taken in order after the sixth
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      open_loop_current_level_out <= '0;
      open_loop_ramp_rate_out     <= '0;
      brake_enable_out            <= 1'b0;
      brake_done_time_out         <= '0;
    end else begin
      open_loop_current_level_out <= CUR_MA[msc_code2_t'(cfg[MSC_IDX_CUR] >> CUR_LSB)];
      open_loop_ramp_rate_out     <= RAMP_MVCC[msc_code3_t'(cfg[MSC_IDX_CUR] >> RAMP_LSB)];
      brake_enable_out            <= msc_code3_t'(cfg[MSC_IDX_CUR]) != '0;
      brake_done_time_out         <= BRAKE_MS[msc_code3_t'(cfg[MSC_IDX_CUR])];
    end
  end

  // ----------------------------------------
  // Start-up acceleration
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      control_coefficient_out  <= '0;
      startup_accel_second_out <= '0;
      startup_accel_first_out  <= '0;
    end else begin
      // Coefficient is reported in quarters, code 0 is one quarter
      control_coefficient_out  <= msc_code3_t'(msc_code2_t'(cfg[MSC_IDX_ACC] >> COEF_LSB)) + 3'h1;
      startup_accel_second_out <= ACC2_CHZ[msc_code3_t'(cfg[MSC_IDX_ACC] >> ACC2_LSB)];
      startup_accel_first_out  <= ACC1_DHZ[msc_code3_t'(cfg[MSC_IDX_ACC])];
    end
  end

  // ----------------------------------------
  // Loop handover and alignment
  // ----------------------------------------
  assign ho_code = msc_code5_t'(cfg[MSC_IDX_HO] >> HO_LSB);

  always_comb begin
    if (ho_code[HO_RANGE_BIT]) begin
      ho_next = msc_ho_t'((msc_nib_t'(ho_code) + 5'h01) * HO_STEP1_DHZ);
    end else begin
      ho_next = msc_ho_t'(msc_nib_t'(ho_code) * HO_STEP0_DHZ);
    end
  end

  // Code zero in the low range has no meaning, flagged invalid
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      loop_handover_threshold_out <= '0;
      loop_handover_valid_out     <= 1'b0;
      rotor_align_time_out        <= '0;
    end else begin
      loop_handover_threshold_out <= ho_next;
      loop_handover_valid_out     <= ho_code != '0;
      rotor_align_time_out        <= ALIGN_MS[msc_code3_t'(cfg[MSC_IDX_HO])];
    end
  end

  // ----------------------------------------
  // Faults, clamping and release
  // ----------------------------------------
  // Inductive clamp bit is stored and read back but drives nothing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fault_detector_enables_out  <= '0;
      mechanical_clamp_enable_out <= 1'b0;
      mechanical_clamp_target_out <= 1'b0;
      sense_release_mode_out      <= 1'b0;
    end else begin
      fault_detector_enables_out  <= msc_nib_t'(cfg[MSC_IDX_FLT] >> FLT_LSB);
      mechanical_clamp_enable_out <= cfg[MSC_IDX_FLT][MECH_EN_BIT];
      mechanical_clamp_target_out <= cfg[MSC_IDX_FLT][MECH_TGT_BIT];
      sense_release_mode_out      <= cfg[MSC_IDX_FLT][REL_MODE_BIT];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence host_wr_s;
    reg_wr_in && !nv_load_in && rd_hit;
  endsequence

  sequence same_rd_s;
    reg_rd_in && !reg_wr_in && (reg_addr_in == $past(reg_addr_in));
  endsequence

  sequence adv_wr_s;
    reg_wr_in && !nv_load_in && (reg_addr_in == MSC_ADV_TIMING_OFS);
  endsequence

  sequence flt_wr_s;
    reg_wr_in && !nv_load_in && (reg_addr_in == MSC_FAULT_OFS);
  endsequence

  write_readback_a: assert property (
    host_wr_s ##1 same_rd_s |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("readback differs from written byte");

  unmapped_read_a: assert property (
    reg_rd_in && !rd_hit |=> reg_rdata_out == MSC_UNMAPPED_RD && !reg_hit_out)
    else $error("unmapped read not zero");

  adv_mode_a: assert property (
    adv_wr_s ##1 !reg_wr_in |=> advance_mode_sel_out == $past(reg_wdata_in[ADV_MODE_BIT], 2))
    else $error("advance mode not from written bit");

  // Outputs hold zero for one edge after reset, so decode checks skip that edge
  adv_cycles_a: assert property (
    !$past(rst_in) |-> advance_time_cycles_out ==
      msc_adv_cyc_t'((18'($past(cfg[MSC_IDX_ADV][3:0])) << $past(cfg[MSC_IDX_ADV][6:4])) * ADV_UNIT_CYC))
    else $error("advance cycles not value times unit");

  adv_value_a: assert property (
    adv_wr_s ##1 !reg_wr_in |=> advance_time_value_out ==
      msc_adv_val_t'(msc_nib_t'($past(reg_wdata_in, 2))) << $past(reg_wdata_in[6:4], 2))
    else $error("advance value not shifted significand");

  stat_thr_a: assert property (
    !$past(rst_in) |-> stationary_threshold_out == STAT_MS[$past(cfg[MSC_IDX_SPD][7:6])])
    else $error("stationary threshold decode wrong");

  sense_angle_a: assert property (
    !$past(rst_in) |-> sense_advance_angle_out == ANGLE_DEG[$past(cfg[MSC_IDX_SPD][5:4])])
    else $error("sense angle decode wrong");

  isd_enable_a: assert property (
    !$past(rst_in) |-> speed_detect_enable_out == $past(cfg[MSC_IDX_SPD][ISD_EN_BIT]))
    else $error("speed detect enable wrong");

  rev_enable_a: assert property (
    $rose(cfg[MSC_IDX_SPD][REV_EN_BIT]) |=> reverse_drive_enable_out)
    else $error("reverse drive enable lags");

  rev_thr_a: assert property (
    !$past(rst_in) |-> reverse_drive_threshold_out == REV_THR_DHZ[$past(cfg[MSC_IDX_SPD][1:0])])
    else $error("reverse threshold decode wrong");

  ol_current_a: assert property (
    !$past(rst_in) |-> open_loop_current_level_out == CUR_MA[$past(cfg[MSC_IDX_CUR][7:6])])
    else $error("open loop current decode wrong");

  ol_ramp_a: assert property (
    !$past(rst_in) |-> open_loop_ramp_rate_out == RAMP_MVCC[$past(cfg[MSC_IDX_CUR][5:3])])
    else $error("ramp rate decode wrong");

  brake_off_a: assert property (
    !brake_enable_out |-> brake_done_time_out == '0)
    else $error("brake time without brake enable");

  brake_code_a: assert property (
    !$past(rst_in) |-> brake_enable_out == ($past(cfg[MSC_IDX_CUR][2:0]) != 3'h0))
    else $error("brake enable decode wrong");

  coef_a: assert property (
    !$past(rst_in) |-> control_coefficient_out == {1'b0, $past(cfg[MSC_IDX_ACC][7:6])} + 3'h1)
    else $error("coefficient decode wrong");

  accel_second_a: assert property (
    !$past(rst_in) |-> startup_accel_second_out == ACC2_CHZ[$past(cfg[MSC_IDX_ACC][5:3])])
    else $error("second order accel decode wrong");

  accel_first_a: assert property (
    !$past(rst_in) |-> startup_accel_first_out == ACC1_DHZ[$past(cfg[MSC_IDX_ACC][2:0])])
    else $error("first order accel decode wrong");

  ho_range1_a: assert property (
    !$past(rst_in) && $past(cfg[MSC_IDX_HO][7]) |->
      loop_handover_threshold_out == 12'h080 * (12'h001 + 12'($past(cfg[MSC_IDX_HO][6:3]))))
    else $error("handover high range wrong");

  ho_range0_a: assert property (
    !$past(rst_in) && !$past(cfg[MSC_IDX_HO][7]) |->
      loop_handover_threshold_out == 12'h008 * 12'($past(cfg[MSC_IDX_HO][6:3])))
    else $error("handover low range wrong");

  align_a: assert property (
    !$past(rst_in) |-> rotor_align_time_out == ALIGN_MS[$past(cfg[MSC_IDX_HO][2:0])])
    else $error("align time decode wrong");

  fault_en_a: assert property (
    flt_wr_s ##1 !reg_wr_in |=> fault_detector_enables_out == $past(reg_wdata_in[7:4], 2))
    else $error("fault enables not from written bits");

  clamp_bits_a: assert property (
    flt_wr_s ##1 !reg_wr_in |=>
      {mechanical_clamp_enable_out, mechanical_clamp_target_out, sense_release_mode_out}
      == $past(reg_wdata_in[2:0], 2))
    else $error("clamp or release bits wrong");

  clamp_target_a: assert property (
    !$past(rst_in) && $changed(cfg[MSC_IDX_FLT][MECH_TGT_BIT]) |=> $changed(mechanical_clamp_target_out))
    else $error("clamp target did not follow");

  release_mode_a: assert property (
    !$past(rst_in) |-> sense_release_mode_out == $past(cfg[MSC_IDX_FLT][REL_MODE_BIT]))
    else $error("release mode wrong");
endmodule
`default_nettype wire

/* msc_pkg.sv */
`default_nettype none
package msc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] MSC_ADV_TIMING_OFS = 8'h22;
  localparam logic [7:0] MSC_SPD_REV_OFS    = 8'h23;
  localparam logic [7:0] MSC_CUR_BRAKE_OFS  = 8'h24;
  localparam logic [7:0] MSC_ACCEL_OFS      = 8'h25;
  localparam logic [7:0] MSC_HANDOVER_OFS   = 8'h26;
  localparam logic [7:0] MSC_FAULT_OFS      = 8'h27;
  localparam int         MSC_NREG           = 6;
  localparam int         MSC_IDX_ADV        = 0;
  localparam int         MSC_IDX_SPD        = 1;
  localparam int         MSC_IDX_CUR        = 2;
  localparam int         MSC_IDX_ACC        = 3;
  localparam int         MSC_IDX_HO         = 4;
  localparam int         MSC_IDX_FLT        = 5;
  localparam logic [7:0] MSC_CFG_RST        = 8'h00;
  localparam logic [7:0] MSC_UNMAPPED_RD    = 8'h00;

  // ----------------------------------------
  // Field positions (lsb of each field)
  // ----------------------------------------
  localparam int ADV_MODE_BIT  = 7;
  localparam int ADV_SHIFT_LSB = 4;
  localparam int STAT_LSB      = 6;
  localparam int ANGLE_LSB     = 4;
  localparam int ISD_EN_BIT    = 3;
  localparam int REV_EN_BIT    = 2;
  localparam int CUR_LSB       = 6;
  localparam int RAMP_LSB      = 3;
  localparam int COEF_LSB      = 6;
  localparam int ACC2_LSB      = 3;
  localparam int HO_LSB        = 3;
  localparam int HO_RANGE_BIT  = 4;
  localparam int FLT_LSB       = 4;
  localparam int MECH_EN_BIT   = 2;
  localparam int MECH_TGT_BIT  = 1;
  localparam int REL_MODE_BIT  = 0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [1:0]  msc_code2_t;
  typedef logic [2:0]  msc_code3_t;
  typedef logic [3:0]  msc_nib_t;
  typedef logic [4:0]  msc_code5_t;
  typedef logic [10:0] msc_adv_val_t;
  typedef logic [17:0] msc_adv_cyc_t;
  typedef logic [11:0] msc_ho_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 32'h0000_0014;
  localparam int ADV_UNIT_NS   = 32'h0000_09C4;
  localparam int ADV_UNIT_CYC  = ADV_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Decode tables, index = field code
  // ----------------------------------------
  // Milliseconds without zero crossing
  localparam logic [9:0] STAT_MS [4] = '{10'h050, 10'h0A0, 10'h140, 10'h280};
  // Degrees
  localparam logic [6:0] ANGLE_DEG [4] = '{7'h1E, 7'h3C, 7'h5A, 7'h78};
  // Tenths of a hertz
  localparam logic [8:0] REV_THR_DHZ [4] = '{9'h03F, 9'h082, 9'h104, 9'h1FE};
  // Milliamperes
  localparam logic [10:0] CUR_MA [4] = '{11'h0C8, 11'h190, 11'h320, 11'h640};
  // Thousandths of supply voltage per second
  localparam logic [12:0] RAMP_MVCC [8] = '{13'h1770, 13'h0BB8, 13'h05DC, 13'h02BC,
                                           13'h0154, 13'h00A0, 13'h0046, 13'h0017};
  // Milliseconds, code 0 means no braking
  localparam logic [12:0] BRAKE_MS [8] = '{13'h0000, 13'h0A8C, 13'h0514, 13'h029E,
                                          13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  // Milliseconds
  localparam logic [12:0] ALIGN_MS [8] = '{13'h14B4, 13'h0A8C, 13'h0514, 13'h029E,
                                          13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  // Hundredths of Hz per second squared
  localparam logic [12:0] ACC2_CHZ [8] = '{13'h1644, 13'h0B54, 13'h0578, 13'h02B2,
                                          13'h014A, 13'h00A0, 13'h0042, 13'h0016};
  // Tenths of Hz per second
  localparam logic [9:0] ACC1_DHZ [8] = '{10'h2F8, 10'h17C, 10'h0BE, 10'h05C,
                                         10'h02D, 10'h015, 10'h009, 10'h003};
  // Handover steps in tenths of a hertz
  localparam int HO_STEP0_DHZ = 32'h0000_0008;
  localparam int HO_STEP1_DHZ = 32'h0000_0080;
endpackage
`default_nettype wire

/* msc_cfg_byte.sv */
`timescale 1ns/100ps
`default_nettype none
module msc_cfg_byte
  import msc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       ld_in,
  input  wire logic [7:0] ld_data_in,
  output logic      [7:0] q_out
);
  logic [7:0] byte_reg;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Stored copy wins over a host write in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      byte_reg <= MSC_CFG_RST;
    end else if (ld_in) begin
      byte_reg <= ld_data_in;
    end else if (wr_in) begin
      byte_reg <= wdata_in;
    end
  end

  assign q_out = byte_reg;
endmodule
`default_nettype wire

/* msc_cfg_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module msc_cfg_bank_tb
  import msc_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        nv_load_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  nv_addr_in = 8'h00;
  logic [7:0]  nv_data_in = 8'h00;
  logic [7:0]  reg_rdata_out;
  logic        reg_hit_out, advance_mode_sel_out, speed_detect_enable_out, reverse_drive_enable_out;
  logic        brake_enable_out, loop_handover_valid_out, mechanical_clamp_enable_out;
  logic        mechanical_clamp_target_out, sense_release_mode_out;
  logic [10:0] advance_time_value_out, open_loop_current_level_out;
  logic [17:0] advance_time_cycles_out;
  logic [9:0]  stationary_threshold_out, startup_accel_first_out;
  logic [6:0]  sense_advance_angle_out;
  logic [8:0]  reverse_drive_threshold_out;
  logic [12:0] open_loop_ramp_rate_out, brake_done_time_out, startup_accel_second_out, rotor_align_time_out;
  logic [2:0]  control_coefficient_out;
  logic [11:0] loop_handover_threshold_out;
  logic [3:0]  fault_detector_enables_out;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          i;
  logic [2:0]  c;
  logic [7:0]  d;
  // Expected decodes, kept apart from the design's own tables
  logic [8:0]  rev_t [4] = '{9'h03F, 9'h082, 9'h104, 9'h1FE};
  logic [12:0] ramp_t [8] = '{13'h1770, 13'h0BB8, 13'h05DC, 13'h02BC, 13'h0154, 13'h00A0, 13'h0046, 13'h0017};
  logic [12:0] brk_t [8] = '{13'h0000, 13'h0A8C, 13'h0514, 13'h029E, 13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  logic [12:0] acc2_t [8] = '{13'h1644, 13'h0B54, 13'h0578, 13'h02B2, 13'h014A, 13'h00A0, 13'h0042, 13'h0016};
  logic [9:0]  acc1_t [8] = '{10'h2F8, 10'h17C, 10'h0BE, 10'h05C, 10'h02D, 10'h015, 10'h009, 10'h003};
  logic [4:0]  ho_c [8] = '{5'h00, 5'h01, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h17, 5'h1F};
  logic [11:0] ho_e [8] = '{12'h000, 12'h008, 12'h038, 12'h040, 12'h078, 12'h080, 12'h400, 12'h800};
  logic [7:0]  flt_v [4] = '{8'hF0, 8'h07, 8'hA5, 8'h52};

  always #10 clk_sys_in = ~clk_sys_in;

  msc_cfg_bank i_msc_cfg_bank (
    .clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .nv_load_in,
    .nv_addr_in, .nv_data_in, .reg_rdata_out, .reg_hit_out, .advance_mode_sel_out,
    .advance_time_value_out, .advance_time_cycles_out, .stationary_threshold_out,
    .sense_advance_angle_out, .speed_detect_enable_out, .reverse_drive_enable_out,
    .reverse_drive_threshold_out, .open_loop_current_level_out, .open_loop_ramp_rate_out,
    .brake_enable_out, .brake_done_time_out, .control_coefficient_out, .startup_accel_second_out,
    .startup_accel_first_out, .loop_handover_threshold_out, .loop_handover_valid_out,
    .rotor_align_time_out, .fault_detector_enables_out, .mechanical_clamp_enable_out,
    .mechanical_clamp_target_out, .sense_release_mode_out
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic nvl(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    nv_load_in <= 1'b1;
    nv_addr_in <= a;
    nv_data_in <= v;
    @(posedge clk_sys_in);
    nv_load_in <= 1'b0;
  endtask

  // Decoded outputs lag the register by one edge, so wait two
  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
    chk(reg_hit_out, hit);
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    settle();
    chk(stationary_threshold_out, 18'h0050);
    chk(open_loop_current_level_out, 18'h00C8);
    chk(control_coefficient_out, 18'h0001);
    chk(rotor_align_time_out, 18'h14B4);
    chk(brake_enable_out, 18'h0000);
    chk(loop_handover_valid_out, 18'h0000);
    for (i = 0; i < 6; i++) rd(MSC_ADV_TIMING_OFS + 8'(i), 8'h00, 1'b1);
    wr(MSC_ADV_TIMING_OFS, 8'h85);
    settle();
    chk(advance_mode_sel_out, 18'h0001);
    chk(advance_time_value_out, 18'h0005);
    chk(advance_time_cycles_out, 18'h0271);
    wr(MSC_ADV_TIMING_OFS, 8'h3A);
    settle();
    chk(advance_mode_sel_out, 18'h0000);
    chk(advance_time_cycles_out, 18'h2710);
    wr(MSC_ADV_TIMING_OFS, 8'h7F);
    settle();
    chk(advance_time_value_out, 18'h0780);
    chk(advance_time_cycles_out, 18'h3_A980);
    for (i = 0; i < 4; i++) begin
      c = 3'(i);
      d = {c[1:0], c[1:0], c[0], c[1], c[1:0]};
      wr(MSC_SPD_REV_OFS, d);
      settle();
      chk(stationary_threshold_out, 18'h0050 << c[1:0]);
      chk(sense_advance_angle_out, 18'h001E * (18'(c) + 18'h0001));
      chk(speed_detect_enable_out, 18'(c[0]));
      chk(reverse_drive_enable_out, 18'(c[1]));
      chk(reverse_drive_threshold_out, 18'(rev_t[c[1:0]]));
      rd(MSC_SPD_REV_OFS, d, 1'b1);
    end
    for (i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(MSC_CUR_BRAKE_OFS, {c[1:0], c, c});
      wr(MSC_ACCEL_OFS, {c[1:0], c, ~c});
      wr(MSC_HANDOVER_OFS, {ho_c[i], c});
      settle();
      chk(open_loop_current_level_out, 18'h00C8 << c[1:0]);
      chk(open_loop_ramp_rate_out, 18'(ramp_t[c]));
      chk(brake_done_time_out, 18'(brk_t[c]));
      chk(brake_enable_out, 18'(c != 3'h0));
      chk(control_coefficient_out, 18'(c[1:0]) + 18'h0001);
      chk(startup_accel_second_out, 18'(acc2_t[c]));
      chk(startup_accel_first_out, 18'(acc1_t[~c]));
      chk(loop_handover_threshold_out, 18'(ho_e[i]));
      chk(loop_handover_valid_out, 18'(ho_c[i] != 5'h00));
      chk(rotor_align_time_out, (c == 3'h0) ? 18'h14B4 : 18'(brk_t[c]));
    end
    // Bit 3 is always written as zero by software
    for (i = 0; i < 4; i++) begin
      d = flt_v[i];
      wr(MSC_FAULT_OFS, d);
      settle();
      chk(fault_detector_enables_out, 18'(d[7:4]));
      chk(mechanical_clamp_enable_out, 18'(d[2]));
      chk(mechanical_clamp_target_out, 18'(d[1]));
      chk(sense_release_mode_out, 18'(d[0]));
      rd(MSC_FAULT_OFS, d, 1'b1);
    end
    wr(8'h28, 8'hFF);
    wr(8'h21, 8'hFF);
    rd(8'h28, 8'h00, 1'b0);
    rd(8'h21, 8'h00, 1'b0);
    rd(MSC_FAULT_OFS, 8'h52, 1'b1);
    // Back-to-back: read during write sees old data, then load beats a write
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_rd_in    <= 1'b1;
    reg_addr_in  <= MSC_ACCEL_OFS;
    reg_wdata_in <= 8'h3C;
    @(posedge clk_sys_in);
    reg_rd_in    <= 1'b0;
    reg_addr_in  <= MSC_HANDOVER_OFS;
    reg_wdata_in <= 8'hC3;
    nv_load_in   <= 1'b1;
    nv_addr_in   <= MSC_HANDOVER_OFS;
    nv_data_in   <= 8'h81;
    #1;
    chk(reg_rdata_out, 18'h00F8);
    @(posedge clk_sys_in);
    reg_wr_in  <= 1'b0;
    nv_load_in <= 1'b0;
    rd(MSC_ACCEL_OFS, 8'h3C, 1'b1);
    rd(MSC_HANDOVER_OFS, 8'h81, 1'b1);
    nvl(MSC_SPD_REV_OFS, 8'hC4);
    settle();
    chk(stationary_threshold_out, 18'h0280);
    chk(speed_detect_enable_out, 18'h0000);
    chk(reverse_drive_enable_out, 18'h0001);
    chk(loop_handover_threshold_out, 18'h0080);
    rd(MSC_SPD_REV_OFS, 8'hC4, 1'b1);
    // Read in the cycle right after a write sees the new byte
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= MSC_ADV_TIMING_OFS;
    reg_wdata_in <= 8'h96;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, 18'h0096);
    // Reset in mid-run clears every byte back to zero
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    settle();
    chk(advance_mode_sel_out, 18'h0000);
    chk(stationary_threshold_out, 18'h0050);
    rd(MSC_FAULT_OFS, 8'h00, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
